// File: hw/fic_pkg.sv
// package: offsets, fields, reset values and carriers for the config bank
package fic_pkg;
  // logical device numbers, placed in haddr[11:10]
  localparam logic [1:0] LDEV_FLOPPY = 2'h0;
  localparam logic [1:0] LDEV_DISK1  = 2'h1;
  localparam logic [1:0] LDEV_DISK2  = 2'h2;
  // register indexes; byte address = ldev * 0x400 + 4 * index
  localparam logic [7:0] IDX_FLOPPY_MODE   = 8'hf0;
  localparam logic [7:0] IDX_FLOPPY_OPTION = 8'hf1;
  localparam logic [7:0] IDX_FLOPPY_TYPE   = 8'hf2;
  localparam logic [7:0] IDX_FLOPPY_ZERO   = 8'hf3;
  localparam logic [7:0] IDX_DRIVE0        = 8'hf4;
  localparam logic [7:0] IDX_DRIVE1        = 8'hf5;
  localparam logic [7:0] IDX_TASK_DEC      = 8'hf0;
  localparam logic [7:0] IDX_AUX_DEC       = 8'hf1;
  localparam logic [7:0] IDX_BUF_MODE      = 8'hf0;
  // reset values
  localparam logic [7:0] RST_FLOPPY_MODE   = 8'h0e;
  localparam logic [7:0] RST_FLOPPY_OPTION = 8'h00;
  localparam logic [7:0] RST_FLOPPY_TYPE   = 8'hff;
  localparam logic [7:0] RST_DRIVE         = 8'h00;
  localparam logic [7:0] RST_TASK_DEC      = 8'h0c;
  localparam logic [7:0] RST_AUX_DEC       = 8'h00;
  localparam logic [7:0] RST_BUF_MODE      = 8'h00;
  // writable bits; everything else stores and reads zero
  localparam logic [7:0] WM_FLOPPY_MODE    = 8'h1f;
  localparam logic [7:0] WM_FLOPPY_OPTION  = 8'hfc;
  localparam logic [7:0] WM_FLOPPY_TYPE    = 8'hff;
  localparam logic [7:0] WM_DRIVE          = 8'h5b;
  localparam logic [7:0] WM_DECODER        = 8'h1f;
  localparam logic [7:0] WM_BUF_MODE       = 8'h01;
  // field positions
  localparam int MODE_ENH_BIT    = 0;
  localparam int MODE_NOBURST    = 1;
  localparam int MODE_IFACE_LO   = 2;
  localparam int MODE_SWAP_BIT   = 4;
  localparam int OPT_DENS_LO     = 2;
  localparam int OPT_MEDIA_LO    = 4;
  localparam int OPT_BOOT_LO     = 6;
  localparam int DRV_TYPE_LO     = 0;
  localparam int DRV_RATE_LO     = 3;
  localparam int DRV_PRECOMP_BIT = 6;
  localparam int DEC_QUAL_LO     = 0;
  localparam int DEC_MASK_LO     = 2;
  localparam int BUF_SHARE_BIT   = 0;
  // density and boot encodings
  localparam logic [1:0] DENS_FORCE1 = 2'h2;
  localparam logic [1:0] DENS_FORCE0 = 2'h3;
  localparam logic [1:0] BOOT_DRV0   = 2'h0;
  localparam logic [1:0] BOOT_DRV1   = 2'h1;
  // strobe qualifier encodings
  localparam logic [1:0] QUAL_AEN    = 2'h0;
  localparam logic [1:0] QUAL_READ   = 2'h1;
  localparam logic [1:0] QUAL_WRITE  = 2'h2;
  localparam logic [1:0] QUAL_EITHER = 2'h3;
  // largest legal mask code (32-byte window)
  localparam logic [2:0] MASK_MAX    = 3'h5;
  // secondary channel windows: task 8 bytes, aux 1 byte
  localparam logic [2:0] SEC_TASK_MASK = 3'h3;
  localparam logic [2:0] SEC_AUX_MASK  = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // isa-side strobes seen by the chip-select decoders
  typedef struct packed {
    logic [11:0] addr;
    logic        aen;
    logic        ior_n;
    logic        iow_n;
  } fic_isa_t;

  // per-drive rate and precompensation settings
  typedef struct packed {
    logic [1:0] drive_type_select;
    logic [1:0] rate_table_select;
    logic       precomp_disable;
  } fic_drive_t;
endpackage

// File: hw/fic_config_regs.sv
// floppy and disk logical-device configuration bank with ahb-lite slave
`timescale 1ns/1ns
module fic_config_regs (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                soft_rst,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  // floppy side
  input  wire logic [1:0]          drive_sel_in,
  input  wire logic [1:0]          motor_sel_in,
  input  wire logic                density_in,
  input  wire logic [1:0]          media_id_in,
  output logic [1:0]               drive_sel_out,
  output logic [1:0]               motor_sel_out,
  output logic                     density_out,
  output logic [1:0]               media_id_out,
  output logic                     enhanced_mode,
  output logic                     burst_dma_en,
  output logic [1:0]               iface_mode,
  output logic [1:0]               boot_drive,
  output logic [7:0]               drive_types,
  output fic_pkg::fic_drive_t      drive0_cfg,
  output fic_pkg::fic_drive_t      drive1_cfg,
  // disk channels
  input  fic_pkg::fic_isa_t        isa,
  input  wire logic [11:0]         task_base,
  input  wire logic [11:0]         aux_base,
  input  wire logic [11:0]         second_task_base,
  input  wire logic [11:0]         second_aux_base,
  input  wire logic                second_active,
  input  wire logic                second_disk_irq_in,
  output logic                     disk_task_select_n,
  output logic                     disk_aux_select_n,
  output logic                     second_task_select_n,
  output logic                     second_task_select_oe,
  output logic                     second_aux_select_n,
  output logic                     second_aux_select_oe,
  output logic                     second_disk_irq_out,
  output logic                     second_disk_irq_oe,
  output logic                     first_buffer_enable_n,
  output logic                     second_buffer_enable_n
);

  logic [7:0] mode_ff;
  logic [7:0] option_ff;
  logic [7:0] type_ff;
  logic [7:0] drv_ff [2];
  logic [7:0] task_dec_ff;
  logic [7:0] aux_dec_ff;
  logic [7:0] buf_mode_ff;
  logic [7:0] nxt_mode;
  logic [7:0] nxt_option;
  logic [7:0] nxt_type;
  logic [7:0] nxt_drv [2];
  logic [7:0] nxt_task_dec;
  logic [7:0] nxt_aux_dec;
  logic [7:0] nxt_buf_mode;
  logic       wr_pend_ff;
  logic [1:0] wr_ldev_ff;
  logic [7:0] wr_idx_ff;
  logic       addr_ok;
  logic       acc;
  logic [7:0] rd_val;
  logic [7:0] wbyte;
  logic       task_hit;
  logic       aux_hit;
  logic       sec_task_hit;
  logic       sec_aux_hit;

  // window compare with the low address bits masked off
  function automatic logic win_hit(input logic [11:0] a,
                                   input logic [11:0] base,
                                   input logic [2:0]  code);
    logic [2:0]  n;
    logic [11:0] m;
    n = (code > fic_pkg::MASK_MAX) ? fic_pkg::MASK_MAX : code;
    m = 12'hfff << n;
    return (a & m) == (base & m);
  endfunction

  // strobe qualifier; aen low means a cpu cycle, not dma
  function automatic logic qual_ok(input fic_pkg::fic_isa_t s,
                                   input logic [1:0] q);
    logic rd;
    logic wr;
    rd = !s.ior_n;
    wr = !s.iow_n;
    unique case (q)
      fic_pkg::QUAL_AEN:    return !s.aen;
      fic_pkg::QUAL_READ:   return !s.aen && rd;
      fic_pkg::QUAL_WRITE:  return !s.aen && wr;
      fic_pkg::QUAL_EITHER: return !s.aen && (rd || wr);
    endcase
  endfunction

  // address phase decode; only the low 4 kB window is mapped
  assign addr_ok = (haddr[31:12] == 20'h00000);
  assign acc     = hsel && hready && (htrans == fic_pkg::HTRANS_NONSEQ);
  assign wbyte   = hwdata[7:0];

  // write data phase: next values fold in the pending write
  always_comb begin
    nxt_mode     = mode_ff;
    nxt_option   = option_ff;
    nxt_type     = type_ff;
    nxt_task_dec = task_dec_ff;
    nxt_aux_dec  = aux_dec_ff;
    nxt_buf_mode = buf_mode_ff;
    nxt_drv[0]   = drv_ff[0];
    nxt_drv[1]   = drv_ff[1];
    if (wr_pend_ff) begin
      unique case (wr_ldev_ff)
        fic_pkg::LDEV_FLOPPY: begin
          if (wr_idx_ff == fic_pkg::IDX_FLOPPY_MODE)
            nxt_mode = wbyte & fic_pkg::WM_FLOPPY_MODE;
          if (wr_idx_ff == fic_pkg::IDX_FLOPPY_OPTION)
            nxt_option = wbyte & fic_pkg::WM_FLOPPY_OPTION;
          if (wr_idx_ff == fic_pkg::IDX_FLOPPY_TYPE)
            nxt_type = wbyte & fic_pkg::WM_FLOPPY_TYPE;
          if (wr_idx_ff == fic_pkg::IDX_DRIVE0)
            nxt_drv[0] = wbyte & fic_pkg::WM_DRIVE;
          if (wr_idx_ff == fic_pkg::IDX_DRIVE1)
            nxt_drv[1] = wbyte & fic_pkg::WM_DRIVE;
        end
        fic_pkg::LDEV_DISK1: begin
          if (wr_idx_ff == fic_pkg::IDX_TASK_DEC)
            nxt_task_dec = wbyte & fic_pkg::WM_DECODER;
          if (wr_idx_ff == fic_pkg::IDX_AUX_DEC)
            nxt_aux_dec = wbyte & fic_pkg::WM_DECODER;
        end
        fic_pkg::LDEV_DISK2: begin
          if (wr_idx_ff == fic_pkg::IDX_BUF_MODE)
            nxt_buf_mode = wbyte & fic_pkg::WM_BUF_MODE;
        end
        default: ;
      endcase
    end
  end

  // read mux on next values so a read right after a write sees it
  always_comb begin
    rd_val = 8'h00;
    if (addr_ok) begin
      unique case (haddr[11:10])
        fic_pkg::LDEV_FLOPPY: begin
          unique case (haddr[9:2])
            fic_pkg::IDX_FLOPPY_MODE:   rd_val = nxt_mode;
            fic_pkg::IDX_FLOPPY_OPTION: rd_val = nxt_option;
            fic_pkg::IDX_FLOPPY_TYPE:   rd_val = nxt_type;
            fic_pkg::IDX_FLOPPY_ZERO:   rd_val = 8'h00;
            fic_pkg::IDX_DRIVE0:        rd_val = nxt_drv[0];
            fic_pkg::IDX_DRIVE1:        rd_val = nxt_drv[1];
            default:                    rd_val = 8'h00;
          endcase
        end
        fic_pkg::LDEV_DISK1: begin
          if (haddr[9:2] == fic_pkg::IDX_TASK_DEC)
            rd_val = nxt_task_dec;
          else if (haddr[9:2] == fic_pkg::IDX_AUX_DEC)
            rd_val = nxt_aux_dec;
        end
        fic_pkg::LDEV_DISK2: begin
          if (haddr[9:2] == fic_pkg::IDX_BUF_MODE)
            rd_val = nxt_buf_mode;
        end
        default: rd_val = 8'h00;
      endcase
    end
  end

  // bus slave: zero wait states, always okay, unmapped reads zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_ldev_ff <= 2'h0;
      wr_idx_ff  <= 8'h00;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= acc && hwrite && addr_ok;
      if (acc) begin
        wr_ldev_ff <= haddr[11:10];
        wr_idx_ff  <= haddr[9:2];
        hrdata     <= {24'h000000, rd_val};
      end
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // floppy bank: hard reset only, soft reset deliberately ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ff   <= fic_pkg::RST_FLOPPY_MODE;
      option_ff <= fic_pkg::RST_FLOPPY_OPTION;
      type_ff   <= fic_pkg::RST_FLOPPY_TYPE;
    end else begin
      mode_ff   <= nxt_mode;
      option_ff <= nxt_option;
      type_ff   <= nxt_type;
    end
  end

  // per-drive registers share one layout and default
  for (genvar d = 0; d < 2; d++) begin : g_drv
    always_ff @(posedge clk) begin
      if (rst)
        drv_ff[d] <= fic_pkg::RST_DRIVE;
      else
        drv_ff[d] <= nxt_drv[d];
    end
  end

  // decoders also take the software reset
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      task_dec_ff <= fic_pkg::RST_TASK_DEC;
      aux_dec_ff  <= fic_pkg::RST_AUX_DEC;
    end else begin
      task_dec_ff <= nxt_task_dec;
      aux_dec_ff  <= nxt_aux_dec;
    end
  end

  // secondary buffer mode: hard reset only
  always_ff @(posedge clk) begin
    if (rst)
      buf_mode_ff <= fic_pkg::RST_BUF_MODE;
    else
      buf_mode_ff <= nxt_buf_mode;
  end

  // floppy control outputs, registered for clean pins
  always_ff @(posedge clk) begin
    if (rst) begin
      enhanced_mode <= 1'b0;
      burst_dma_en  <= 1'b0;
      iface_mode    <= 2'h3;
      drive_sel_out <= 2'h0;
      motor_sel_out <= 2'h0;
      density_out   <= 1'b0;
      media_id_out  <= 2'h0;
      boot_drive    <= 2'h1;
      drive_types   <= 8'hff;
    end else begin
      enhanced_mode <= mode_ff[fic_pkg::MODE_ENH_BIT];
      burst_dma_en  <= !mode_ff[fic_pkg::MODE_NOBURST];
      iface_mode    <= mode_ff[fic_pkg::MODE_IFACE_LO +: 2];
      if (mode_ff[fic_pkg::MODE_SWAP_BIT]) begin
        drive_sel_out <= {drive_sel_in[0], drive_sel_in[1]};
        motor_sel_out <= {motor_sel_in[0], motor_sel_in[1]};
      end else begin
        drive_sel_out <= drive_sel_in;
        motor_sel_out <= motor_sel_in;
      end
      unique case (option_ff[fic_pkg::OPT_DENS_LO +: 2])
        fic_pkg::DENS_FORCE1: density_out <= 1'b1;
        fic_pkg::DENS_FORCE0: density_out <= 1'b0;
        default:              density_out <= density_in;
      endcase
      media_id_out <= media_id_in
                      ^ option_ff[fic_pkg::OPT_MEDIA_LO +: 2];
      // one-hot boot drive; code 11 also means no boot drive
      unique case (option_ff[fic_pkg::OPT_BOOT_LO +: 2])
        fic_pkg::BOOT_DRV0: boot_drive <= 2'h1;
        fic_pkg::BOOT_DRV1: boot_drive <= 2'h2;
        default:            boot_drive <= 2'h0;
      endcase
      drive_types <= type_ff;
    end
  end

  // drive rate and precompensation fields
  always_ff @(posedge clk) begin
    if (rst) begin
      drive0_cfg <= '0;
      drive1_cfg <= '0;
    end else begin
      drive0_cfg <= '{drive_type_select: drv_ff[0][fic_pkg::DRV_TYPE_LO +: 2],
                      rate_table_select: drv_ff[0][fic_pkg::DRV_RATE_LO +: 2],
                      precomp_disable:
                        drv_ff[0][fic_pkg::DRV_PRECOMP_BIT]};
      drive1_cfg <= '{drive_type_select: drv_ff[1][fic_pkg::DRV_TYPE_LO +: 2],
                      rate_table_select: drv_ff[1][fic_pkg::DRV_RATE_LO +: 2],
                      precomp_disable:
                        drv_ff[1][fic_pkg::DRV_PRECOMP_BIT]};
    end
  end

  // chip-select decode; reserved mask codes clamp to the widest window
  assign task_hit = win_hit(isa.addr, task_base,
                            task_dec_ff[fic_pkg::DEC_MASK_LO +: 3])
                    && qual_ok(isa, task_dec_ff[fic_pkg::DEC_QUAL_LO +: 2]);
  assign aux_hit  = win_hit(isa.addr, aux_base,
                            aux_dec_ff[fic_pkg::DEC_MASK_LO +: 3])
                    && qual_ok(isa, aux_dec_ff[fic_pkg::DEC_QUAL_LO +: 2]);
  assign sec_task_hit = second_active
                        && win_hit(isa.addr, second_task_base,
                                   fic_pkg::SEC_TASK_MASK)
                        && qual_ok(isa, fic_pkg::QUAL_EITHER);
  assign sec_aux_hit  = second_active
                        && win_hit(isa.addr, second_aux_base,
                                   fic_pkg::SEC_AUX_MASK)
                        && qual_ok(isa, fic_pkg::QUAL_EITHER);

  // disk pins; one cycle of decode latency traded for flop-driven pins
  always_ff @(posedge clk) begin
    if (rst) begin
      disk_task_select_n     <= 1'b1;
      disk_aux_select_n      <= 1'b1;
      second_task_select_n   <= 1'b1;
      second_aux_select_n    <= 1'b1;
      second_task_select_oe  <= 1'b0;
      second_aux_select_oe   <= 1'b0;
      second_disk_irq_out    <= 1'b0;
      second_disk_irq_oe     <= 1'b0;
      first_buffer_enable_n  <= 1'b1;
      second_buffer_enable_n <= 1'b1;
    end else begin
      disk_task_select_n    <= !task_hit;
      disk_aux_select_n     <= !aux_hit;
      second_task_select_n  <= !sec_task_hit;
      second_aux_select_n   <= !sec_aux_hit;
      second_task_select_oe <= second_active;
      second_aux_select_oe  <= second_active;
      second_disk_irq_out   <= second_active && second_disk_irq_in;
      second_disk_irq_oe    <= second_active;
      // shared mode routes secondary bytes through the primary buffer
      first_buffer_enable_n <= !(task_hit || aux_hit
        || (buf_mode_ff[fic_pkg::BUF_SHARE_BIT]
            && (sec_task_hit || sec_aux_hit)));
      second_buffer_enable_n <= buf_mode_ff[fic_pkg::BUF_SHARE_BIT]
        || !(sec_task_hit || sec_aux_hit);
    end
  end

endmodule // fic_config_regs

// File: testbench/fic_config_regs_checker.sv
// concurrent checks on the ports of the config bank
`timescale 1ns/1ns
module fic_config_regs_checker (
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         hsel,
  input wire logic [31:0]  haddr,
  input wire logic [1:0]   htrans,
  input wire logic         hwrite,
  input wire logic         hready,
  input wire logic [31:0]  hrdata,
  input wire logic [1:0]   drive_sel_in,
  input wire logic [1:0]   motor_sel_in,
  input wire logic [1:0]   drive_sel_out,
  input wire logic [1:0]   motor_sel_out,
  input wire logic         enhanced_mode,
  input wire logic         burst_dma_en,
  input wire logic [1:0]   iface_mode,
  input wire logic [1:0]   boot_drive,
  input fic_pkg::fic_isa_t isa,
  input wire logic         disk_task_select_n,
  input wire logic         disk_aux_select_n,
  input wire logic         second_active,
  input wire logic         second_task_select_oe,
  input wire logic         second_aux_select_oe,
  input wire logic         second_disk_irq_oe,
  input wire logic         first_buffer_enable_n
);
  logic live_ff;
  logic wr1_ff;
  logic wr2_ff;
  logic wr3_ff;
  logic mode_wr;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // mode write accepted; register moves at the data edge, the pins one
  // edge later, and the change is seen in sampled values one edge after
  assign mode_wr = hsel && hready && hwrite && haddr == 32'h3c0 &&
                   htrans == fic_pkg::HTRANS_NONSEQ;
  // live_ff keeps $past from looking into a reset cycle
  always_ff @(posedge clk) begin
    live_ff <= !rst;
    wr1_ff  <= mode_wr && !rst;
    wr2_ff  <= wr1_ff;
    wr3_ff  <= wr2_ff;
  end

  sequence s_rd_zero;
    hsel && hready && !hwrite && haddr == 32'h3cc &&
    htrans == fic_pkg::HTRANS_NONSEQ;
  endsequence

  a_zero_index: assert property (
    s_rd_zero |=> hrdata == 32'h0) else $error("reserved index not zero");
  a_read_pad: assert property (
    hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_mode_cause: assert property (
    $changed({enhanced_mode, burst_dma_en, iface_mode}) |-> wr3_ff)
    else $error("mode outputs moved without a mode write");
  a_swap_pair: assert property (
    live_ff && $past(drive_sel_in) == 2'h1 && $past(motor_sel_in) == 2'h1
    |-> drive_sel_out == motor_sel_out && ^drive_sel_out)
    else $error("drive and motor selects not swapped together");
  a_boot_code: assert property (
    boot_drive != 2'h3) else $error("two boot drives named");
  a_sec_float: assert property (
    live_ff |-> {second_task_select_oe, second_aux_select_oe,
                 second_disk_irq_oe} == {3{$past(second_active)}})
    else $error("secondary pins not floated per active bit");
  a_dma_block: assert property (
    live_ff && $past(isa.aen) |-> disk_task_select_n && disk_aux_select_n)
    else $error("chip select during dma cycle");
  a_buf_follow: assert property (
    !disk_task_select_n || !disk_aux_select_n |-> !first_buffer_enable_n)
    else $error("primary buffer not enabled on select");
endmodule // fic_config_regs_checker

bind fic_config_regs fic_config_regs_checker chk (
  .clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .drive_sel_in, .motor_sel_in, .drive_sel_out, .motor_sel_out,
  .enhanced_mode, .burst_dma_en, .iface_mode, .boot_drive, .isa,
  .disk_task_select_n, .disk_aux_select_n, .second_active,
  .second_task_select_oe, .second_aux_select_oe, .second_disk_irq_oe,
  .first_buffer_enable_n
);

// File: testbench/fic_host.sv
// ahb-lite host model that programs the configuration bank
`timescale 1ns/1ns
module fic_host (
  input  wire logic        clk,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  // bus idle from time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // single word transfer; no wait count assumed, the bench timeout cuts hangs
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= fic_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    // released data lines flip so a stale value is never mistaken
    hwdata <= ~d;
  endtask
endmodule // fic_host

// File: testbench/test_floppy_ide_ldev_config_regs.sv
// self-checking bench for the floppy and disk configuration bank
`timescale 1ns/1ns
module test_floppy_ide_ldev_config_regs;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                soft_rst, hsel, hwrite, hreadyout, hresp, density_in;
  logic                density_out, enhanced_mode, burst_dma_en, second_active;
  logic                second_disk_irq_in, second_disk_irq_out;
  logic                disk_task_select_n, disk_aux_select_n;
  logic                second_task_select_n, second_aux_select_n;
  logic                second_task_select_oe, second_aux_select_oe;
  logic                second_disk_irq_oe, first_buffer_enable_n;
  logic                second_buffer_enable_n, pt, pa, st, sa, bm;
  logic [1:0]          htrans, drive_sel_in, motor_sel_in, media_id_in;
  logic [1:0]          drive_sel_out, motor_sel_out, media_id_out;
  logic [1:0]          iface_mode, boot_drive;
  logic [2:0]          hsize;
  logic [7:0]          drive_types, md, op;
  logic [11:0]         task_base, aux_base, second_task_base, second_aux_base;
  logic [31:0]         haddr, hwdata, hrdata, rnd;
  fic_pkg::fic_isa_t   isa;
  fic_pkg::fic_drive_t drive0_cfg, drive1_cfg;
  int                  fail_count, compares, cyc, seed;
  logic [7:0]          mdl [11];
  // model table: address, writable bits, reset value of each place
  logic [31:0] adr [11] = '{32'h3c0, 32'h3c4, 32'h3c8, 32'h3cc, 32'h3d0,
    32'h3d4, 32'h7c0, 32'h7c4, 32'hbc0, 32'h3d8, 32'hfc0};
  logic [7:0]  msk [11] = '{8'h1f, 8'hfc, 8'hff, 8'h00, 8'h5b, 8'h5b,
    8'h1f, 8'h1f, 8'h01, 8'h00, 8'h00};
  logic [7:0]  rv [11] = '{8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00,
    8'h0c, 8'h00, 8'h00, 8'h00, 8'h00};

  fic_host host (.clk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata);
  fic_config_regs dut (.clk, .rst, .soft_rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .drive_sel_in, .motor_sel_in, .density_in, .media_id_in,
    .drive_sel_out, .motor_sel_out, .density_out, .media_id_out,
    .enhanced_mode, .burst_dma_en, .iface_mode, .boot_drive, .drive_types,
    .drive0_cfg, .drive1_cfg, .isa, .task_base, .aux_base,
    .second_task_base, .second_aux_base, .second_active, .second_disk_irq_in,
    .disk_task_select_n, .disk_aux_select_n, .second_task_select_n,
    .second_task_select_oe, .second_aux_select_n, .second_aux_select_oe,
    .second_disk_irq_out, .second_disk_irq_oe, .first_buffer_enable_n,
    .second_buffer_enable_n);

  // 250 MHz clock
  always #2 clk = ~clk;

  task complete_run();
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task hard_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    mdl = rv;
  endtask

  // upper data bits are random; only the low byte is stored
  task wr(input int k, input logic [7:0] d);
    logic [31:0] r;
    host.xfer(1'b1, adr[k], {24'($random(seed)), d}, r);
    mdl[k] = d & msk[k];
  endtask

  task rd(input int k);
    logic [31:0] r;
    host.xfer(1'b0, adr[k], 32'h0, r);
    check({7'h0, hresp, r}, {8'h0, 24'h0, mdl[k]});
  endtask

  // window hit: mask code clears low address bits, qualifier picks strobes
  function automatic logic hit(logic [11:0] b, logic [2:0] m, logic [1:0] q);
    logic [11:0] k;
    k = ~((12'h1 << m) - 12'h1);
    return !isa.aen && ((isa.addr & k) == (b & k)) &&
      (q == 2'h0 || (q[0] && !isa.ior_n) || (q[1] && !isa.iow_n));
  endfunction

  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    seed = 60;
    {soft_rst, density_in, second_active, second_disk_irq_in} = 4'h0;
    {drive_sel_in, motor_sel_in, media_id_in} = 6'h0;
    {task_base, aux_base, second_task_base, second_aux_base} = 48'h0;
    isa = '0;
    hard_reset();
    for (int k = 0; k < 11; k++) rd(k);
    // all ones, all zeros, random: reserved bits must read zero
    for (int n = 0; n < 3; n++)
      for (int k = 0; k < 11; k++) begin
        wr(k, n == 0 ? 8'hff : n == 1 ? 8'h00 : 8'($random(seed)));
        rd(k);
      end
    // every mode, density and boot code, with random floppy inputs
    for (int i = 0; i < 32; i++) begin
      rnd = $random(seed);
      wr(0, {rnd[7:5], i[4:0]});
      wr(1, {i[1:0], rnd[5:4], i[3:2], rnd[1:0]});
      wr(2, rnd[15:8]);
      wr(4, rnd[23:16]);
      wr(5, rnd[31:24]);
      rnd = $random(seed);
      drive_sel_in <= i[0] ? 2'h1 : rnd[1:0];
      motor_sel_in <= i[0] ? 2'h1 : rnd[3:2];
      density_in <= rnd[4];
      media_id_in <= rnd[6:5];
      repeat (2) @(posedge clk);
      #1;
      md = mdl[0];
      op = mdl[1];
      check({9'h0, enhanced_mode, burst_dma_en, iface_mode, drive_sel_out,
        motor_sel_out, density_out, media_id_out, boot_drive, drive_types,
        drive0_cfg, drive1_cfg}, {9'h0, md[0], !md[1], md[3:2],
        md[4] ? {drive_sel_in[0], drive_sel_in[1]} : drive_sel_in,
        md[4] ? {motor_sel_in[0], motor_sel_in[1]} : motor_sel_in,
        op[3] ? !op[2] : density_in, media_id_in ^ op[5:4],
        op[7:6] == 2'h0 ? 2'h1 : op[7:6] == 2'h1 ? 2'h2 : 2'h0, mdl[2],
        mdl[4][1:0], mdl[4][4:3], mdl[4][6], mdl[5][1:0], mdl[5][4:3],
        mdl[5][6]});
    end
    // every legal mask and qualifier code against random isa cycles
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      wr(6, {rnd[7:5], 3'(i / 4), 2'(i % 4)});
      wr(7, {rnd[15:13], 3'(5 - i / 4), 2'(i % 4) ^ 2'h1});
      wr(8, rnd[23:16]);
      task_base <= rnd[11:0];
      aux_base <= rnd[27:16];
      second_task_base <= ~rnd[11:0];
      second_aux_base <= ~rnd[27:16];
      for (int j = 0; j < 6; j++) begin
        @(posedge clk);
        rnd = $random(seed);
        isa.addr <= (rnd[0] ? (rnd[1] ? second_aux_base : second_task_base)
          : (rnd[1] ? aux_base : task_base)) ^ {6'h0, rnd[14] ? rnd[7:2] : 6'h0};
        isa.aen <= rnd[9:8] == 2'h0;
        isa.ior_n <= rnd[10];
        isa.iow_n <= rnd[11];
        second_active <= rnd[12];
        second_disk_irq_in <= rnd[13];
        repeat (2) @(posedge clk);
        #1;
        pt = hit(task_base, mdl[6][4:2], mdl[6][1:0]);
        pa = hit(aux_base, mdl[7][4:2], mdl[7][1:0]);
        st = second_active && hit(second_task_base, 3'h3, 2'h3);
        sa = second_active && hit(second_aux_base, 3'h0, 2'h3);
        bm = mdl[8][0];
        check({30'h0, disk_task_select_n, disk_aux_select_n,
          second_task_select_n, second_aux_select_n, second_task_select_oe,
          second_aux_select_oe, second_disk_irq_oe,
          second_disk_irq_out & second_active, first_buffer_enable_n,
          second_buffer_enable_n}, {30'h0, !pt, !pa, !st, !sa,
          {3{second_active}}, second_disk_irq_in & second_active,
          !(pt || pa || ((st || sa) && bm)), !((st || sa) && !bm)});
      end
    end
    // soft reset restores only the two decoders
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    mdl[6] = 8'h0c;
    mdl[7] = 8'h00;
    for (int k = 0; k < 11; k++) rd(k);
    hard_reset();
    for (int k = 0; k < 11; k++) rd(k);
    complete_run();
  end
endmodule // test_floppy_ide_ldev_config_regs
